/* File: core/uei_top.v */
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "uei_regs.vh"

// usb error interrupt gating with an axi4-lite register slave
module uei_top (
    input wire clk,
    input wire rst_n,
    // error events from the serial interface engine, same clock
    input wire stuff_error_event,
    input wire turnaround_timeout_event,
    input wire field_size_error_event,
    input wire data_crc_fail_event,
    input wire token_crc_fail_event,
    input wire pid_check_fail_event,
    // gated summary toward the core interrupt logic
    output reg top_error_interrupt,
    // write address channel
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // read address channel
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // implemented bit positions of both registers
    localparam [7:0] IMPL = `UEI_IMPL_MASK;

    // software enable register
    reg [7:0] usb_error_enable;
    // next enable value, seen by the interrupt path
    reg [7:0] next_enable;
    // sticky flags and their next value
    wire [7:0] usb_error_status;
    wire [7:0] next_status;
    // event vector in register bit order
    wire [7:0] set_vec;
    // software clear request, one bit per flag
    reg [7:0] clr_vec;
    // next interrupt level
    wire next_interrupt;
    // any flag pending, enabled or not
    wire any_flag;

    // captured write address and data
    reg aw_held;
    reg [7:0] aw_addr_q;
    reg w_held;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    // both halves present and response slot free
    wire do_write;
    // write decode
    wire wr_enable;
    wire wr_status;
    wire wr_summary;
    wire wr_mapped;
    // low byte lane written
    wire wr_lane0;

    // read decode
    wire rd_take;
    reg [31:0] rd_value;
    reg rd_mapped;

    // --------------------------------------------------------------
    // event mapping
    // --------------------------------------------------------------

    // events land on their flag positions; 6-5 stay zero
    assign set_vec[`UEI_STUFF_BIT] = stuff_error_event;
    assign set_vec[6] = 1'b0;
    assign set_vec[5] = 1'b0;
    assign set_vec[`UEI_TURNAROUND_BIT] = turnaround_timeout_event;
    assign set_vec[`UEI_FIELD_SIZE_BIT] = field_size_error_event;
    assign set_vec[`UEI_DATA_CRC_BIT] = data_crc_fail_event;
    assign set_vec[`UEI_TOKEN_CRC_BIT] = token_crc_fail_event;
    assign set_vec[`UEI_PID_BIT] = pid_check_fail_event;

    // --------------------------------------------------------------
    // flag bank
    // --------------------------------------------------------------

    // flags ignore the enables entirely, so polling still works
    uei_flags u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set_vec(set_vec),
        .clr_vec(clr_vec),
        .next_flags(next_status),
        .flags(usb_error_status)
    );

    // --------------------------------------------------------------
    // write channel capture
    // --------------------------------------------------------------

    // accept each half while its holder is empty and no response waits
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;

    // commit once both halves are held
    assign do_write = aw_held & w_held & ~s_axi_bvalid;

    // decode on the word address; low two bits ignored
    assign wr_enable = aw_addr_q[7:2] == `UEI_ENABLE_OFFSET >> 2;
    assign wr_status = aw_addr_q[7:2] == `UEI_STATUS_OFFSET >> 2;
    assign wr_summary = aw_addr_q[7:2] == `UEI_SUMMARY_OFFSET >> 2;
    assign wr_mapped = wr_enable | wr_status | wr_summary;
    assign wr_lane0 = w_strb_q[0];

    // address holder, either order with data is fine
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // data holder
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // write response, held until the master takes it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UEI_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            // unmapped words answer slave error
            if (wr_mapped) begin
                s_axi_bresp <= `UEI_RESP_OKAY;
            end else begin
                s_axi_bresp <= `UEI_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // register effects of a write
    // --------------------------------------------------------------

    // next enable; missing bits forced low so they read zero
    always @* begin
        next_enable = usb_error_enable;
        if (do_write && wr_enable && wr_lane0) begin
            next_enable = w_data_q[7:0] & IMPL;
        end
    end

    // zero written to a status bit clears it; one leaves it alone
    always @* begin
        clr_vec = 8'h00;
        if (do_write && wr_status && wr_lane0) begin
            clr_vec = ~w_data_q[7:0] & IMPL;
        end
    end

    // enable storage; each bit steers its own source
    // bit 7 stuff, 4 turnaround, 3 field size, 2 data crc,
    // 1 token crc, 0 pid check
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            usb_error_enable <= `UEI_ENABLE_RESET;
        end else begin
            usb_error_enable <= next_enable;
        end
    end

    // --------------------------------------------------------------
    // interrupt aggregation
    // --------------------------------------------------------------

    // built from next values, so a new flag or a new enable shows
    // at the very edge that stores it, with no extra cycle of lag
    assign next_interrupt = |(next_status & next_enable);
    assign any_flag = |usb_error_status;

    // registered level; a core on another clock can sample it with
    // its own synchroniser since it never glitches between edges
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_error_interrupt <= 1'b0;
        end else begin
            top_error_interrupt <= next_interrupt;
        end
    end

    // --------------------------------------------------------------
    // read channel
    // --------------------------------------------------------------

    // one read outstanding; address taken when no data waits
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_take = s_axi_arvalid & s_axi_arready;

    // read mux; unused upper bits read zero
    always @* begin
        rd_value = 32'h00000000;
        rd_mapped = 1'b1;
        case (s_axi_araddr[7:2])
            `UEI_ENABLE_OFFSET >> 2: begin
                rd_value[7:0] = usb_error_enable & IMPL;
            end
            `UEI_STATUS_OFFSET >> 2: begin
                rd_value[7:0] = usb_error_status & IMPL;
            end
            `UEI_SUMMARY_OFFSET >> 2: begin
                rd_value[`UEI_SUM_INTERRUPT_BIT] = top_error_interrupt;
                rd_value[`UEI_SUM_ANY_FLAG_BIT] = any_flag;
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // read data register, held until the master takes it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `UEI_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            // unmapped words give zero data and slave error
            if (rd_mapped) begin
                s_axi_rresp <= `UEI_RESP_OKAY;
            end else begin
                s_axi_rresp <= `UEI_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // protection bits carry no meaning here; the whole map is open
    // to any master, which keeps the slave simple

endmodule

/* File: core/uei_regs.vh */
// Notes on behaviour
// - enabled flag drives top error interrupt
// - flags set regardless of their enable
// - enable bit 7: bit stuff error
// - enable bits 6-5 read zero, ignore writes
// - enable bit 4: turnaround time-out
// - enable bit 3: data field size error
// - enable bit 2: data crc failure
// - enable bit 1: token crc failure
// - enable bit 0: pid check failure
// - usb logic runs from 48 MHz
// - core may use another clock
// - top bit is OR of enabled flags
// - flag sets in its detection cycle
// - flag clears only by written zero
`ifndef UEI_REGS_VH
`define UEI_REGS_VH

// register byte offsets on the slave bus
`define UEI_ENABLE_OFFSET 8'h00
`define UEI_STATUS_OFFSET 8'h04
`define UEI_SUMMARY_OFFSET 8'h08

// field positions shared by enable and status
`define UEI_STUFF_BIT 7
`define UEI_TURNAROUND_BIT 4
`define UEI_FIELD_SIZE_BIT 3
`define UEI_DATA_CRC_BIT 2
`define UEI_TOKEN_CRC_BIT 1
`define UEI_PID_BIT 0

// summary register fields
`define UEI_SUM_INTERRUPT_BIT 0
`define UEI_SUM_ANY_FLAG_BIT 1

// bits 6-5 do not exist in either register
`define UEI_IMPL_MASK 8'h9f

// reset values
`define UEI_ENABLE_RESET 8'h00
`define UEI_STATUS_RESET 8'h00

// axi response codes
`define UEI_RESP_OKAY 2'b00
`define UEI_RESP_SLVERR 2'b10

// nominal usb logic clock, in hertz
`define UEI_USB_CLK_HZ 48000000

`endif

/* File: core/uei_flags.v */
`timescale 1ns/1ps
`include "uei_regs.vh"

// sticky error flag bank, one flip-flop per implemented bit
module uei_flags (
    input wire clk,
    input wire rst_n,
    input wire [7:0] set_vec,
    input wire [7:0] clr_vec,
    output wire [7:0] next_flags,
    output reg [7:0] flags
);

    // which bit positions really hold storage
    localparam [7:0] IMPL = `UEI_IMPL_MASK;

    genvar i;

    generate
        for (i = 0; i < 8; i = i + 1) begin : g_flag
            if (IMPL[i]) begin : g_impl
                // set wins over a clear in the same cycle
                assign next_flags[i] = set_vec[i] |
                    (flags[i] & ~clr_vec[i]);

                // flag storage, set on the detection edge
                always @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        flags[i] <= 1'b0;
                    end else begin
                        flags[i] <= next_flags[i];
                    end
                end
            end else begin : g_none
                // unimplemented position, constant zero
                assign next_flags[i] = 1'b0;

                always @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        flags[i] <= 1'b0;
                    end else begin
                        flags[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule

/* File: test/uei_sie_model.sv */
`timescale 1ns/1ps
// stand-in for the serial engine: one-cycle error pulses
module uei_sie_model (
    input wire clk,
    output wire stuff_error_event,
    output wire turnaround_timeout_event,
    output wire field_size_error_event,
    output wire data_crc_fail_event,
    output wire token_crc_fail_event,
    output wire pid_check_fail_event
);
    // event lines packed like the status bits
    logic [7:0] ev = 8'h00;
    assign stuff_error_event = ev[7];
    assign turnaround_timeout_event = ev[4];
    assign field_size_error_event = ev[3];
    assign data_crc_fail_event = ev[2];
    assign token_crc_fail_event = ev[1];
    assign pid_check_fail_event = ev[0];
    // one pulse per call; bits 6-5 have no source
    task pulse(input logic [7:0] v);
        @(posedge clk);
        ev <= v & 8'h9f;
        @(posedge clk);
        ev <= 8'h00;
    endtask
endmodule

/* File: test/uei_checker.sv */
`timescale 1ns/1ps
// port-level watcher for gating and bus handshakes
module uei_checker (
    input wire clk,
    input wire rst_n,
    input wire stuff_error_event, turnaround_timeout_event,
    input wire field_size_error_event, data_crc_fail_event,
    input wire token_crc_fail_event, pid_check_fail_event,
    input wire top_error_interrupt,
    input wire s_axi_awvalid, s_axi_awready,
    input wire s_axi_wvalid, s_axi_wready,
    input wire s_axi_bvalid, s_axi_bready,
    input wire s_axi_arvalid, s_axi_arready,
    input wire s_axi_rvalid, s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    // any error source firing this cycle
    wire ev_any = stuff_error_event | turnaround_timeout_event |
        field_size_error_event | data_crc_fail_event |
        token_crc_fail_event | pid_check_fail_event;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // top bit rises only from an event or an enable write
    property p_rise;
        $rose(top_error_interrupt) |->
            $past(ev_any) || $rose(s_axi_bvalid);
    endproperty
    a_rise: assert property (p_rise) else $error("top rose without cause");
    // flags are sticky, so only a write can drop the top bit
    property p_fall;
        $fell(top_error_interrupt) |-> $rose(s_axi_bvalid);
    endproperty
    a_fall: assert property (p_fall) else $error("top fell without write");
    property p_blat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_blat: assert property (p_blat) else $error("write answer late");
    property p_awblk;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_awblk: assert property (p_awblk) else $error("write taken early");
    property p_bdrop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bdrop: assert property (p_bdrop) else $error("bvalid stuck");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rdrop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdrop: assert property (p_rdrop) else $error("rvalid stuck");
    c_rise: cover property ($rose(top_error_interrupt));
    c_fall: cover property ($fell(top_error_interrupt));
    c_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind uei_top uei_checker chk (.*);

/* File: test/uei_top_tb.sv */
`timescale 1ns/1ps
`include "uei_regs.vh"
// self-checking bench for the error gating block
module uei_top_tb;
    logic clk = 0, rst_n = 0;
    wire stuff_error_event, turnaround_timeout_event;
    wire field_size_error_event, data_crc_fail_event;
    wire token_crc_fail_event, pid_check_fail_event;
    wire top_error_interrupt;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int error_cnt = 0, total_checks = 0;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    // implemented bit positions, msb first
    int bits[6] = '{7, 4, 3, 2, 1, 0};
    uei_top uut (.*);
    uei_sie_model sie (.*);
    initial forever #2.5 clk = ~clk;
    // compare and count
    task chk(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // axi write; halves sampled mid-cycle, released after their edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        n = 0;
        tb = 0;
        while (!tb) begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rd_resp = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            n++;
        end
        s_axi_bready <= 0;
    endtask
    // axi read; rready comes late so the slave must hold its answer
    task rd(input logic [7:0] a);
        int n;
        logic tk;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        n = 0;
        do begin
            @(negedge clk);
            tk = s_axi_arvalid && s_axi_arready;
            @(posedge clk);
            n++;
        end while (!tk);
        s_axi_arvalid <= 0;
        @(posedge clk);
        s_axi_rready <= 1;
        do begin
            @(negedge clk);
            tk = s_axi_rvalid;
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            @(posedge clk);
            n++;
        end while (!tk);
        s_axi_rready <= 0;
    endtask
    task t_reset;
        rd(`UEI_ENABLE_OFFSET);
        chk("enable", rd_data, `UEI_ENABLE_RESET);
        rd(`UEI_STATUS_OFFSET);
        chk("status", rd_data, `UEI_STATUS_RESET);
        chk("top", top_error_interrupt, 0);
        $display("t_reset done");
    endtask
    // disabled sources still set their flags at once
    task t_poll;
        logic [7:0] exp;
        exp = 0;
        foreach (bits[i]) begin
            sie.pulse(8'h01 << bits[i]);
            exp[bits[i]] = 1;
            rd(`UEI_STATUS_OFFSET);
            chk("top", top_error_interrupt, 0);
            chk("status", rd_data, {24'h0, exp});
        end
        $display("t_poll done");
    endtask
    // each enable bit gates exactly its own flag
    task t_gate;
        logic [7:0] b;
        foreach (bits[i]) begin
            b = 8'h01 << bits[i];
            wr(`UEI_STATUS_OFFSET, 0);
            sie.pulse(b);
            wr(`UEI_ENABLE_OFFSET, {24'h0, `UEI_IMPL_MASK ^ b});
            chk("top off", top_error_interrupt, 0);
            wr(`UEI_ENABLE_OFFSET, {24'h0, b});
            chk("top on", top_error_interrupt, 1);
            rd(`UEI_SUMMARY_OFFSET);
            chk("summary", rd_data, 32'h3);
            rd(`UEI_ENABLE_OFFSET);
            chk("enable", rd_data, {24'h0, b});
        end
        wr(`UEI_ENABLE_OFFSET, 32'hff);
        rd(`UEI_ENABLE_OFFSET);
        chk("enable", rd_data, {24'h0, `UEI_IMPL_MASK});
        $display("t_gate done");
    endtask
    // zero clears a flag, one leaves it
    task t_clear;
        sie.pulse(8'hff);
        wr(`UEI_STATUS_OFFSET, 32'hfe);
        rd(`UEI_STATUS_OFFSET);
        chk("status", rd_data, 32'h9e);
        wr(`UEI_STATUS_OFFSET, 32'hff);
        rd(`UEI_STATUS_OFFSET);
        chk("status", rd_data, 32'h9e);
        wr(`UEI_ENABLE_OFFSET, 32'h01);
        chk("top", top_error_interrupt, 0);
        wr(`UEI_STATUS_OFFSET, 0);
        rd(`UEI_STATUS_OFFSET);
        chk("status", rd_data, 0);
        $display("t_clear done");
    endtask
    task t_badaddr;
        rd(8'h40);
        chk("rresp", rd_resp, `UEI_RESP_SLVERR);
        chk("rdata", rd_data, 0);
        wr(8'h40, 32'hff);
        chk("bresp", rd_resp, `UEI_RESP_SLVERR);
        $display("t_badaddr done");
    endtask
    // hang guard, far beyond the roughly 180 cycles needed
    initial begin
        #50000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_reset;
        t_poll;
        t_gate;
        t_clear;
        t_badaddr;
        wrap_up;
    end
endmodule
